// *** rtl/serial_word_link_pkg.sv ***
/*
 * Shared constants and types for the redundant serial word link.
 * Assumes a 250 MHz core clock and a host channel carrying 12-bit words.
 */
package serial_word_link_pkg;

    // ==========================================================
    // Word format
    localparam int WORD_BITS = 12;
    localparam logic [4:0] IDX_ERR_CLR = 5'h09;
    localparam logic [4:0] IDX_COPY = 5'h0b;
    localparam logic [4:0] IDX_REPEAT = 5'h0c;
    localparam logic [4:0] IDX_RDY_NARROW = 5'h0b;
    localparam logic [4:0] IDX_RDY_WIDE = 5'h16;
    localparam logic [4:0] IDX_LAST = 5'h17;
    localparam logic [4:0] IDX_END = 5'h18;

    // ==========================================================
    // Function codes: upper six bits select, lower six bits act
    localparam logic [5:0] SEL_WIDE = 6'h38;
    localparam logic [5:0] SEL_NARROW = 6'h1c;
    localparam logic [5:0] FN_TRANSMIT = 6'h01;
    localparam logic [5:0] FN_RECEIVE = 6'h02;
    localparam logic [5:0] FN_SENSE = 6'h03;

    // ==========================================================
    // Register map
    localparam logic [2:0] ADDR_CTRL = 3'h0;
    localparam logic [2:0] ADDR_WORD_GAP = 3'h1;
    localparam logic [2:0] ADDR_BLOCK_GAP = 3'h2;
    localparam logic [2:0] ADDR_STATUS = 3'h3;
    localparam int CTRL_WIDE = 0;
    localparam int CTRL_WBB = 1;
    localparam int CTRL_WAIT_LO = 2;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] WORD_GAP_RESET = 16'h0000;
    localparam logic [15:0] BLOCK_GAP_RESET = 16'h0000;
    localparam logic [15:0] GAP_SATURATED = 16'hffff;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int BIT_HALF_NS = 500;
    localparam int BIT_HALF_CYCLES = BIT_HALF_NS / CLK_PERIOD_NS;
    localparam logic [7:0] BIT_HALF_LAST = 8'(BIT_HALF_CYCLES - 1);
    localparam logic [7:0] BIT_FULL_LAST = 8'(2 * BIT_HALF_CYCLES - 1);
    localparam int SETTLE_NS = 200;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] SETTLE_LAST = 8'(SETTLE_CYCLES - 1);
    localparam int BLOCK_NULL_NS = 3000;
    localparam int BLOCK_NULL_CYCLES = BLOCK_NULL_NS / CLK_PERIOD_NS;
    localparam logic [9:0] BLOCK_NULL_COUNT = 10'(BLOCK_NULL_CYCLES);
    localparam int FAKE_MIN_US = 100;
    localparam int FAKE_MIN_CYCLES = (FAKE_MIN_US * 1000) / CLK_PERIOD_NS;

    // ==========================================================
    // Transmit sequencer
    typedef enum logic [5:0] {
        TX_IDLE = 6'h01,
        TX_SETTLE = 6'h02,
        TX_GAP = 6'h04,
        TX_ALIGN = 6'h08,
        TX_SHIFT = 6'h10,
        TX_RESUME = 6'h20
    } tx_state_t;

endpackage : serial_word_link_pkg

// *** rtl/redundant_serial_word_link.sv ***
/*
 * Word sequencer between a host parallel channel and a redundant serial line.
 * Each 12-bit host word goes out as 24 line bits (data then repeat); the
 * receiver rebuilds words, checks the repeat and hands words to the host.
 * Assumes all inputs synchronous to core_clk and a line that raises
 * line_present for the 24 bits of each word.
 */
`timescale 1ns/100ps
module redundant_serial_word_link #(
    parameter int FAKE_DELAY_CYCLES = serial_word_link_pkg::FAKE_MIN_CYCLES
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic master_clear,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic [11:0] external_function_code,
    input wire logic func_ready,
    input wire logic [11:0] out_data,
    input wire logic out_ready,
    output logic out_resume,
    output logic [11:0] in_data,
    output logic in_error_bit,
    output logic in_ready,
    input wire logic in_resume,
    output logic line_tx,
    output logic line_tx_en,
    input wire logic line_rx,
    input wire logic line_present
);

    // ==========================================================
    // Registers reached by software
    logic [15:0] ctrl;
    logic [15:0] word_gap_control;
    logic [15:0] block_gap_delay;
    logic [15:0] status;
    logic [15:0] rd_value;

    wire wide_mode = ctrl[serial_word_link_pkg::CTRL_WIDE];
    wire wait_block_start_mode = ctrl[serial_word_link_pkg::CTRL_WBB];
    wire [1:0] wait_length_selector =
        ctrl[serial_word_link_pkg::CTRL_WAIT_LO +: 2];

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrl <= serial_word_link_pkg::CTRL_RESET;
            word_gap_control <= serial_word_link_pkg::WORD_GAP_RESET;
            block_gap_delay <= serial_word_link_pkg::BLOCK_GAP_RESET;
        end else if (reg_wr) begin
            if (reg_addr == serial_word_link_pkg::ADDR_CTRL) ctrl <= reg_wdata & 16'h000f;
            if (reg_addr == serial_word_link_pkg::ADDR_WORD_GAP) word_gap_control <= reg_wdata;
            if (reg_addr == serial_word_link_pkg::ADDR_BLOCK_GAP) block_gap_delay <= reg_wdata;
        end
    end

    assign rd_value =
        (reg_addr == serial_word_link_pkg::ADDR_CTRL) ? ctrl :
        (reg_addr == serial_word_link_pkg::ADDR_WORD_GAP) ? word_gap_control :
        (reg_addr == serial_word_link_pkg::ADDR_BLOCK_GAP) ? block_gap_delay :
        (reg_addr == serial_word_link_pkg::ADDR_STATUS) ? status : 16'h0000;
    always_ff @(posedge core_clk) begin
        if (!rstn) reg_rdata <= 16'h0000;
        else reg_rdata <= reg_rd ? rd_value : 16'h0000;
    end

    // ==========================================================
    // Clock phases
    logic phase_odd;

    always_ff @(posedge core_clk) begin
        if (!rstn) phase_odd <= 1'b0;
        else phase_odd <= ~phase_odd;
    end

    // ==========================================================
    // Function decode
    logic tx_selected;
    logic rx_selected;
    logic rx_sel_d;
    logic fn_resume;
    logic first_of_block;

    wire [5:0] sel_value = wide_mode ? serial_word_link_pkg::SEL_WIDE
                                     : serial_word_link_pkg::SEL_NARROW;
    wire code_match = func_ready && (external_function_code[11:6] == sel_value);
    wire [5:0] fn_act = external_function_code[5:0];
    wire decode_tx = code_match && (fn_act == serial_word_link_pkg::FN_TRANSMIT);
    wire decode_rx = code_match && (fn_act == serial_word_link_pkg::FN_RECEIVE);
    wire decode_sense = code_match && (fn_act == serial_word_link_pkg::FN_SENSE);
    wire decode_any = decode_tx || decode_rx || decode_sense;
    wire sense_clear = master_clear || decode_sense;
    wire rx_sel_rise = rx_selected && !rx_sel_d;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_selected <= 1'b0;
            rx_selected <= 1'b0;
            rx_sel_d <= 1'b0;
        end else begin
            rx_sel_d <= rx_selected;
            if (sense_clear || decode_rx) tx_selected <= 1'b0;
            else if (decode_tx) tx_selected <= 1'b1;
            if (sense_clear || decode_tx) rx_selected <= 1'b0;
            else if (decode_rx) rx_selected <= 1'b1;
        end
    end

    // Narrow host holds function ready until this answer
    always_ff @(posedge core_clk) begin
        if (!rstn) fn_resume <= 1'b0;
        else if (!func_ready) fn_resume <= 1'b0;
        else if (decode_any && !wide_mode) fn_resume <= 1'b1;
    end

    // ==========================================================
    // Transmit sequencer
    serial_word_link_pkg::tx_state_t tx_state;
    logic [7:0] settle_cnt;
    logic [7:0] tx_div;
    logic tx_half_odd;
    logic [4:0] tx_idx;
    logic [11:0] holding;
    logic [11:0] shifter;
    logic [15:0] gap_cnt;
    logic timing_enable;
    logic data_ready;
    logic word_resume;

    wire transmitting = (tx_state == serial_word_link_pkg::TX_ALIGN) ||
                        (tx_state == serial_word_link_pkg::TX_SHIFT);
    wire gap_ok = (gap_cnt >= word_gap_control) &&
                  (!first_of_block || gap_cnt >= block_gap_delay);
    wire tx_div_wrap = (tx_div == serial_word_link_pkg::BIT_HALF_LAST);
    wire tx_even_out = tx_div_wrap && tx_half_odd;
    wire [4:0] tx_idx_next = tx_idx + 5'h01;
    wire [4:0] tx_pos_wide = (tx_idx_next >= serial_word_link_pkg::IDX_REPEAT)
                             ? tx_idx_next - serial_word_link_pkg::IDX_REPEAT
                             : tx_idx_next;
    wire [3:0] tx_pos = tx_pos_wide[3:0];

    assign out_resume = fn_resume || (word_resume && data_ready);

    always_ff @(posedge core_clk) begin
        if (!rstn) gap_cnt <= serial_word_link_pkg::GAP_SATURATED;
        else if (transmitting) gap_cnt <= 16'h0000;
        else if (gap_cnt != serial_word_link_pkg::GAP_SATURATED) gap_cnt <= gap_cnt + 16'h0001;
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) first_of_block <= 1'b1;
        else if (decode_tx) first_of_block <= 1'b1;
        else if (tx_state == serial_word_link_pkg::TX_SHIFT) first_of_block <= 1'b0;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_div <= 8'h00;
            tx_half_odd <= 1'b0;
        end else if (!timing_enable) begin
            tx_div <= 8'h00;
            tx_half_odd <= 1'b0;
        end else if (tx_div_wrap) begin
            tx_div <= 8'h00;
            tx_half_odd <= ~tx_half_odd;
        end else begin
            tx_div <= tx_div + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_state <= serial_word_link_pkg::TX_IDLE;
            settle_cnt <= 8'h00;
            holding <= 12'h000;
            shifter <= 12'h000;
            tx_idx <= 5'h00;
            timing_enable <= 1'b0;
            data_ready <= 1'b0;
            word_resume <= 1'b0;
            line_tx <= 1'b0;
            line_tx_en <= 1'b0;
        end else begin
            case (tx_state)
                serial_word_link_pkg::TX_IDLE: begin
                    settle_cnt <= 8'h00;
                    if (tx_selected && out_ready) tx_state <= serial_word_link_pkg::TX_SETTLE;
                end
                serial_word_link_pkg::TX_SETTLE: begin
                    settle_cnt <= settle_cnt + 8'h01;
                    if (settle_cnt == serial_word_link_pkg::SETTLE_LAST) begin
                        holding <= out_data;
                        tx_state <= serial_word_link_pkg::TX_GAP;
                    end
                end
                serial_word_link_pkg::TX_GAP: begin
                    shifter <= holding;
                    if (gap_ok && phase_odd) begin
                        timing_enable <= 1'b1;
                        tx_state <= serial_word_link_pkg::TX_ALIGN;
                    end
                end
                serial_word_link_pkg::TX_ALIGN: begin
                    if (tx_even_out) begin
                        tx_idx <= 5'h00;
                        line_tx <= shifter[0];
                        line_tx_en <= 1'b1;
                        data_ready <= 1'b1;
                        tx_state <= serial_word_link_pkg::TX_SHIFT;
                    end
                end
                serial_word_link_pkg::TX_SHIFT: begin
                    if (tx_even_out) begin
                        if (tx_idx == serial_word_link_pkg::IDX_LAST) begin
                            holding <= 12'h000;
                            shifter <= 12'h000;
                            line_tx <= 1'b0;
                            line_tx_en <= 1'b0;
                            timing_enable <= 1'b0;
                            word_resume <= 1'b1;
                            tx_state <= serial_word_link_pkg::TX_RESUME;
                        end else begin
                            tx_idx <= tx_idx_next;
                            line_tx <= shifter[tx_pos];
                        end
                    end
                end
                serial_word_link_pkg::TX_RESUME: begin
                    if (!out_ready) begin
                        word_resume <= 1'b0;
                        data_ready <= 1'b0;
                        tx_state <= serial_word_link_pkg::TX_IDLE;
                    end
                end
                default: tx_state <= serial_word_link_pkg::TX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Receive bit timing, restarted by incoming data
    logic [7:0] rx_div;
    logic [4:0] rx_idx;
    logic [11:0] rx_hold;
    logic [11:0] rx_cmp;

    wire rx_run = line_present && !transmitting;
    wire rx_sample = rx_run && (rx_div == serial_word_link_pkg::BIT_HALF_LAST) &&
                     (rx_idx < serial_word_link_pkg::IDX_END);
    wire [4:0] rx_rep_wide = rx_idx - serial_word_link_pkg::IDX_REPEAT;
    wire [3:0] rx_rep = rx_rep_wide[3:0];
    wire in_repeat = rx_idx >= serial_word_link_pkg::IDX_REPEAT;
    wire mismatch = rx_sample && in_repeat && (line_rx != rx_cmp[rx_rep]);

    always_ff @(posedge core_clk) begin
        if (!rstn || !rx_run) begin
            rx_div <= 8'h00;
            rx_idx <= 5'h00;
            rx_hold <= 12'h000;
        end else begin
            rx_div <= (rx_div == serial_word_link_pkg::BIT_FULL_LAST) ? 8'h00 : rx_div + 8'h01;
            if (rx_sample) begin
                rx_idx <= rx_idx + 5'h01;
                if (!in_repeat) rx_hold[rx_idx[3:0]] <= line_rx;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) rx_cmp <= 12'h000;
        else if (rx_sample && rx_idx == serial_word_link_pkg::IDX_COPY)
            rx_cmp <= {line_rx, rx_hold[10:0]};
    end

    // ==========================================================
    // Error flags
    logic word_err;
    logic block_err;
    logic last_word_ok;

    wire word_err_now = word_err || mismatch;
    always_ff @(posedge core_clk) begin
        if (!rstn) word_err <= 1'b0;
        else if (mismatch) word_err <= 1'b1;
        else if (rx_sample && rx_idx == serial_word_link_pkg::IDX_ERR_CLR)
            word_err <= 1'b0;
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) last_word_ok <= 1'b1;
        else if (rx_sample && rx_idx == serial_word_link_pkg::IDX_LAST)
            last_word_ok <= !word_err_now;
    end
    // A fresh error beats a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rstn) block_err <= 1'b0;
        else if (mismatch) block_err <= 1'b1;
        else if (sense_clear && last_word_ok) block_err <= 1'b0;
    end

    // ==========================================================
    // Block start and line silence
    logic [9:0] null_cnt;
    logic start_ok;
    logic [17:0] fake_cnt;
    logic fake_ready;
    logic got_word;

    wire null_done = (null_cnt == serial_word_link_pkg::BLOCK_NULL_COUNT);
    wire data_arriving = line_present || (rx_idx != 5'h00);
    wire [17:0] fake_unit = 18'(FAKE_DELAY_CYCLES);
    wire [17:0] fake_limit = (wait_length_selector == 2'h1) ? fake_unit :
                             (wait_length_selector == 2'h2) ? {fake_unit[16:0], 1'b0} :
                             {fake_unit[15:0], 2'b00};
    wire fake_timing = rx_selected && !line_present && (wait_length_selector != 2'h0);
    always_ff @(posedge core_clk) begin
        if (!rstn || line_present) null_cnt <= 10'h000;
        else if (!null_done) null_cnt <= null_cnt + 10'h001;
    end
    always_ff @(posedge core_clk) begin
        if (!rstn || !rx_selected) start_ok <= 1'b0;
        else if (rx_sel_rise) start_ok <= !(wait_block_start_mode && data_arriving);
        else if (null_done) start_ok <= 1'b1;
    end
    always_ff @(posedge core_clk) begin
        if (!rstn || !fake_timing) fake_cnt <= 18'h00000;
        else if (fake_cnt != fake_limit) fake_cnt <= fake_cnt + 18'h00001;
    end
    always_ff @(posedge core_clk) begin
        if (!rstn || !rx_selected) fake_ready <= 1'b0;
        else if (fake_timing && fake_cnt == fake_limit) fake_ready <= 1'b1;
    end

    // ==========================================================
    // Handing words to the host
    wire rdy_idx = wide_mode ? (rx_idx == serial_word_link_pkg::IDX_RDY_WIDE)
                             : (rx_idx == serial_word_link_pkg::IDX_RDY_NARROW);
    wire word_hand = rx_sample && rdy_idx && rx_selected && start_ok;
    wire fake_hand = fake_ready && !in_ready && !in_resume;
    wire [11:0] rx_word = wide_mode ? rx_cmp : {line_rx, rx_hold[10:0]};
    always_ff @(posedge core_clk) begin
        if (!rstn || !rx_selected) got_word <= 1'b0;
        else if (word_hand) got_word <= 1'b1;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            in_ready <= 1'b0;
            in_data <= 12'h000;
            in_error_bit <= 1'b0;
        end else if (word_hand) begin
            in_ready <= 1'b1;
            in_data <= rx_word;
            in_error_bit <= wide_mode && word_err_now;
        end else if (fake_hand) begin
            in_ready <= 1'b1;
            in_data <= got_word ? in_data : 12'h000;
            in_error_bit <= 1'b0;
        end else if (in_resume) begin
            in_ready <= 1'b0;
        end
    end

    // ==========================================================
    // Status word
    assign status = {8'h00, start_ok, transmitting, line_present, fake_ready,
                     block_err, word_err, rx_selected, tx_selected};

endmodule : redundant_serial_word_link

// *** verification/link_port_sva.sv ***
/*
 * Port checker for the redundant serial word link.
 * Assumes one core_clk domain and synchronous active-low rstn.
 */
`timescale 1ns/100ps
module link_port_sva (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic func_ready,
    input wire logic out_ready,
    input wire logic out_resume,
    input wire logic [11:0] in_data,
    input wire logic in_ready,
    input wire logic in_resume,
    input wire logic line_tx,
    input wire logic line_tx_en
);
    localparam int TX_EN_CYCLES = 6000;
    logic [12:0] en_cnt;
    logic [7:0] ph;
    // ==========================================================
    // Counters of driven cycles and bit phase
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            en_cnt <= 13'h0;
            ph <= 8'h0;
        end else begin
            en_cnt <= line_tx_en ? en_cnt + 13'h1 : 13'h0;
            ph <= (line_tx_en && ph != 8'hf9) ? ph + 8'h1 : 8'h0;
        end
    end
    // ==========================================================
    // Properties
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_resume_low;
        ##[1:2] !out_resume;
    endsequence
    a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("read data outside answer cycle");
    a_tx_word_len: assert property ($fell(line_tx_en) |-> en_cnt == TX_EN_CYCLES)
        else $error("line word length wrong");
    a_tx_bit_hold: assert property (line_tx_en && ph != 8'h0 |-> $stable(line_tx))
        else $error("line bit changed inside bit time");
    a_tx_after_word: assert property ($rose(line_tx_en) |->
        out_ready && !out_resume)
        else $error("drivers enabled without host word");
    a_tx_resume: assert property ($fell(line_tx_en) |-> ##[0:2] out_resume)
        else $error("no output resume after word");
    a_resume_release: assert property (out_resume && !out_ready
        && !func_ready |-> s_resume_low)
        else $error("output resume not released");
    a_ready_drop: assert property (in_ready && in_resume |-> ##[1:2] !in_ready)
        else $error("input ready not dropped on resume");
    a_word_held: assert property (in_ready && $past(in_ready) |-> $stable(in_data))
        else $error("input word changed under input ready");
endmodule : link_port_sva
bind redundant_serial_word_link link_port_sva i_link_port_sva (.core_clk(core_clk), .rstn(rstn),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .func_ready(func_ready), .out_ready(out_ready),
    .out_resume(out_resume), .in_data(in_data), .in_ready(in_ready), .in_resume(in_resume),
    .line_tx(line_tx), .line_tx_en(line_tx_en));

// *** verification/line_host_model.sv ***
/*
 * Far-side model: remote line sender and host input handshake.
 * Assumes the bench holds word and corrupt steady while a word is sent.
 */
`timescale 1ns/100ps
module line_host_model (
    input wire logic core_clk,
    input wire logic send,
    input wire logic [11:0] word,
    input wire logic corrupt,
    input wire logic in_ready,
    output logic line_rx,
    output logic line_present,
    output logic in_resume
);
    logic [12:0] cnt = 13'h0;
    logic idle_bit = 1'b0;
    wire logic [4:0] idx = 5'(cnt / 13'd250);
    wire logic [4:0] pos = (idx >= 5'd12) ? idx - 5'd12 : idx;
    wire logic bitv = word[pos[3:0]] ^ (corrupt && idx == 5'd12);
    // Idle line toggles so a stale level is never mistaken for data
    assign line_rx = line_present ? bitv : idle_bit;
    initial begin
        line_present = 1'b0;
        in_resume = 1'b0;
    end
    always @(posedge core_clk) begin
        idle_bit <= ~idle_bit;
        in_resume <= in_ready;
        if (send && !line_present) begin
            line_present <= 1'b1;
            cnt <= 13'h0;
        end else if (line_present) begin
            cnt <= cnt + 13'h1;
            if (cnt == 13'd5999) begin
                line_present <= 1'b0;
            end
        end
    end
endmodule : line_host_model

// *** verification/tb.sv ***
/*
 * Self-checking bench: register port, function channel, transmit and receive.
 * Assumes the line host model on the far side and a 250 MHz core clock.
 */
`timescale 1ns/100ps
module tb;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [11:0] external_function_code = 12'h0;
    logic func_ready = 1'b0;
    logic [11:0] out_data = 12'h0;
    logic out_ready = 1'b0;
    logic send = 1'b0;
    logic corrupt = 1'b0;
    logic [11:0] word = 12'h0;
    logic master_clear = 1'b0;
    wire logic [15:0] reg_rdata;
    wire logic [11:0] in_data;
    wire logic out_resume, in_error_bit, in_ready, in_resume;
    wire logic line_tx, line_tx_en, line_rx, line_present;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2 core_clk = ~core_clk;
    redundant_serial_word_link #(.FAKE_DELAY_CYCLES(20)) i_redundant_serial_word_link (
        .core_clk(core_clk), .rstn(rstn), .master_clear(master_clear), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_function_code(external_function_code), .func_ready(func_ready),
        .out_data(out_data), .out_ready(out_ready), .out_resume(out_resume),
        .in_data(in_data), .in_error_bit(in_error_bit), .in_ready(in_ready),
        .in_resume(in_resume), .line_tx(line_tx), .line_tx_en(line_tx_en),
        .line_rx(line_rx), .line_present(line_present));
    line_host_model i_line_host_model (.core_clk(core_clk), .send(send), .word(word),
        .corrupt(corrupt), .in_ready(in_ready), .line_rx(line_rx),
        .line_present(line_present), .in_resume(in_resume));
    // ==========================================================
    // Tasks
    task close_out;
        if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task reg_write(input logic [2:0] a, input logic [15:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [2:0] a, input logic [15:0] mask, input logic [15:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check("register", exp, reg_rdata & mask);
    endtask : reg_read
    task func(input logic [5:0] sel, input logic [5:0] act, input bit hold_fixed);
        @(posedge core_clk);
        external_function_code <= {sel, act};
        func_ready <= 1'b1;
        if (hold_fixed) repeat (2000) @(posedge core_clk);
        else begin
            @(posedge core_clk);
            while (out_resume !== 1'b1) @(posedge core_clk);
        end
        func_ready <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : func
    task rx_word(input logic [11:0] w, input bit c, input bit wide);
        @(posedge core_clk);
        word <= w;
        corrupt <= c;
        send <= 1'b1;
        @(posedge core_clk);
        send <= 1'b0;
        while (in_ready !== 1'b1) @(posedge core_clk);
        check("in_data", {4'h0, w}, {4'h0, in_data});
        if (wide) check("in_error_bit", {15'h0, c}, {15'h0, in_error_bit});
        while (line_present) @(posedge core_clk);
        repeat (800) @(posedge core_clk);
    endtask : rx_word
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            err_total++;
            close_out();
        end
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        reg_read(serial_word_link_pkg::ADDR_STATUS, 16'h001f, 16'h0000);
        reg_read(serial_word_link_pkg::ADDR_CTRL, 16'hffff, serial_word_link_pkg::CTRL_RESET);
        reg_write(3'h7, 16'h1234);
        reg_read(3'h7, 16'hffff, 16'h0000);
        func(serial_word_link_pkg::SEL_WIDE, serial_word_link_pkg::FN_RECEIVE, 1);
        reg_read(serial_word_link_pkg::ADDR_STATUS, 16'h0003, 16'h0000);
        func(serial_word_link_pkg::SEL_NARROW, serial_word_link_pkg::FN_TRANSMIT, 0);
        reg_read(serial_word_link_pkg::ADDR_STATUS, 16'h0003, 16'h0001);
        @(posedge core_clk);
        out_data <= 12'ha5c;
        out_ready <= 1'b1;
        while (line_tx_en !== 1'b1) @(posedge core_clk);
        repeat (125) @(posedge core_clk);
        for (int i = 0; i < 24; i++) begin
            check("line_tx", {15'h0, out_data[i % 12]}, {15'h0, line_tx});
            repeat (250) @(posedge core_clk);
        end
        while (out_resume !== 1'b1) @(posedge core_clk);
        out_ready <= 1'b0;
        repeat (3) @(posedge core_clk);
        check("out_resume", 16'h0, {15'h0, out_resume});
        func(serial_word_link_pkg::SEL_NARROW, serial_word_link_pkg::FN_RECEIVE, 0);
        reg_read(serial_word_link_pkg::ADDR_STATUS, 16'h0003, 16'h0002);
        rx_word(12'h3c9, 0, 0);
        rx_word(12'h5a6, 1, 0);
        reg_read(serial_word_link_pkg::ADDR_STATUS, 16'h000c, 16'h000c);
        rx_word(12'h0f1, 0, 0);
        reg_read(serial_word_link_pkg::ADDR_STATUS, 16'h000c, 16'h0008);
        func(serial_word_link_pkg::SEL_NARROW, serial_word_link_pkg::FN_SENSE, 0);
        reg_read(serial_word_link_pkg::ADDR_STATUS, 16'h000f, 16'h0000);
        reg_write(serial_word_link_pkg::ADDR_CTRL, 16'h0001);
        func(serial_word_link_pkg::SEL_WIDE, serial_word_link_pkg::FN_RECEIVE, 1);
        rx_word(12'h6b3, 1, 1);
        rx_word(12'h247, 0, 1);
        reg_read(serial_word_link_pkg::ADDR_STATUS, 16'h000e, 16'h000a);
        @(posedge core_clk);
        master_clear <= 1'b1;
        @(posedge core_clk);
        master_clear <= 1'b0;
        reg_read(serial_word_link_pkg::ADDR_STATUS, 16'h000f, 16'h0000);
        reg_write(serial_word_link_pkg::ADDR_CTRL, 16'h0005);
        func(serial_word_link_pkg::SEL_WIDE, serial_word_link_pkg::FN_RECEIVE, 1);
        while (in_ready !== 1'b1) @(posedge core_clk);
        check("fake in_data", 16'h0000, {4'h0, in_data});
        reg_read(serial_word_link_pkg::ADDR_STATUS, 16'h0010, 16'h0010);
        close_out();
    end
endmodule : tb
